// ---- design/boot_gate_pkg.sv ----
// Purpose: Shared constants for the boot-loader password gate and its controller
// Assumes: Byte-wide link, 16-bit flash address space
// Notes:   Pointers travel as 3 bytes, most significant first
package boot_gate_pkg;
  // ==========================================================
  // Commands
  localparam logic [7:0]  CMD_ERASE     = 8'hf0;
  localparam logic [7:0]  CMD_WRITE     = 8'h30;
  localparam logic [7:0]  CMD_READ      = 8'h40;
  localparam logic [7:0]  CMD_LOADER    = 8'h60;
  localparam logic [7:0]  CMD_SECURE    = 8'hfa;
  localparam logic [7:0]  CMD_STATUS    = 8'hc3;
  // ==========================================================
  // Address windows and values
  localparam logic [23:0] WIN_LO        = 24'h008000;
  localparam logic [23:0] WIN_HI        = 24'h00feff;
  localparam logic [23:0] CMP_LIMIT     = 24'h00ff00;
  localparam logic [7:0]  MIN_LEN       = 8'h07;
  localparam logic [15:0] BLANK_LO      = 16'hffe0;
  localparam logic [5:0]  BLANK_CNT     = 6'h20;
  localparam logic [15:0] OPT_ADDR      = 16'hfffa;
  localparam logic [7:0]  ERASED        = 8'hff;
  localparam logic [7:0]  REC_START     = 8'h3a;
  localparam logic [1:0]  RUN_LIMIT     = 2'h2;
  localparam logic [2:0]  PTR_BYTES     = 3'h6;
  // ==========================================================
  // Status response layout
  localparam int          STAT_BLANK    = 0;
  localparam int          STAT_PROT     = 1;
  // ==========================================================
  // Helpers
  function automatic logic in_win(input logic [23:0] a, input logic [23:0] hi);
    in_win = (a >= WIN_LO) && (a <= hi);
  endfunction : in_win

  function automatic logic gated_cmd(input logic [7:0] c);
    gated_cmd = (c == CMD_ERASE) || (c == CMD_WRITE) || (c == CMD_READ) ||
                (c == CMD_LOADER) || (c == CMD_SECURE);
  endfunction : gated_cmd
endpackage : boot_gate_pkg

// ---- design/boot_link_if.sv ----
// Purpose: Byte link between the external controller and the gate
// Assumes: Both ends on one clock
// Notes:   Controller to device is valid/ready; device to controller is a pulse
`timescale 1ns/100ps
interface boot_link_if;
  logic       h2d_valid;
  logic [7:0] h2d_data;
  logic       h2d_ready;
  logic       d2h_valid;
  logic [7:0] d2h_data;

  modport dev (input h2d_valid, input h2d_data, output h2d_ready,
               output d2h_valid, output d2h_data);
  modport ctl (output h2d_valid, output h2d_data, input h2d_ready,
               input d2h_valid, input d2h_data);
endinterface : boot_link_if

// ---- design/run_check.sv ----
// Purpose: Flags a byte that would be the third identical one in a row
// Assumes: Cleared before each password string
// Notes:   run3 is combinational on the offered byte
`timescale 1ns/100ps
module run_check (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       clear,
  input  wire logic       valid,
  input  wire logic [7:0] data,
  output logic            run3
);
  import boot_gate_pkg::*;
  logic [7:0] prev_r;
  logic [1:0] cnt_r;

  // Third occurrence of the same byte in a row
  assign run3 = valid && (cnt_r == RUN_LIMIT) && (data == prev_r);

  // Track length of the current run
  always_ff @(posedge clk) begin
    if (rst || clear) begin
      prev_r <= 8'h00;
      cnt_r  <= 2'h0;
    end else if (valid) begin
      prev_r <= data;
      if (cnt_r != 2'h0 && data == prev_r) begin
        if (cnt_r != RUN_LIMIT) cnt_r <= cnt_r + 2'h1;
      end else begin
        cnt_r <= 2'h1;
      end
    end
  end
endmodule : run_check

// ---- design/boot_gate.sv ----
// Purpose: Password gate in front of the serial boot-loader command set
// Assumes: FLASH_DATA shows the byte at the address FLASH_ADDR held at the last edge
// Notes:   Lock state is left only by SYS_RST
// Behaviour
// R1 - Passwords live in flash 0x8000..0xFEFF
// R2 - Length byte below 0x07 or bad pointer fails
// R3 - Non-blank compare pointer at most 0xFF00-N
// R4 - Compare N received bytes against flash
// R5 - Mismatch or triple repeat fails, locks
// R6 - Locked device ignores link until reset
// R7 - Blank when 0xFFE0..0xFFFF all 0xFF
// R8 - Blank part: pointers checked, string skipped
// R9 - Gated commands need pointers and password
// R10 - Grant only after authentication, else lock
// R11 - Pointer errors: no response, lock
// R12 - Blank write/loader: discard until 0x3A
// R13 - Controller omits dummy string for blank; boot_ctl omits it only for erase, write and loader
// R14 - Controller sends no string for blank erase
// R15 - Chip erase makes part blank again
// R16 - Parallel mode: only protection flag restricts
// R17 - Debug start needs successful authentication
// R18 - Protection flag blocks access commands
// R19 - 0xFA sets flag, chip erase clears
// R20 - Status response reports blank state
// R21 - Option byte 0xFF skips string for erase
// R22 - Locked: discard bytes, transmit nothing
`timescale 1ns/100ps
module boot_gate (
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  boot_link_if.dev         LINK,
  output logic [15:0]      FLASH_ADDR,
  input  wire logic [7:0]  FLASH_DATA,
  input  wire logic        PAR_MODE,
  input  wire logic        DEBUG_REQ,
  input  wire logic        OP_DONE,
  input  wire logic        OP_ABORT,
  input  wire logic        CHIP_ERASE_DONE,
  output logic             OP_VALID,
  output logic [7:0]       OP_CMD,
  output logic             OP_BYPASS,
  output logic             LOCKED,
  output logic             BLANK,
  output logic             PROTECTED,
  output logic             PAR_ACCESS_OK,
  output logic             DEBUG_START
);
  import boot_gate_pkg::*;

  typedef enum {ST_SCAN, ST_CMD, ST_PTR, ST_LEN, ST_PW, ST_HUNT, ST_BUSY,
                ST_LOCK} gate_e;

  gate_e       state_r;
  logic [15:0] flash_addr_r;
  logic [15:0] addr_prev_r;
  logic        data_ok;
  logic [5:0]  scan_r;
  logic        blank_r;
  logic        blank_acc_r;
  logic        opt_free_r;
  logic        prot_r;
  logic        auth_r;
  logic [7:0]  cmd_r;
  logic [2:0]  ptr_cnt_r;
  logic [23:0] len_ptr_r;
  logic [23:0] cmp_ptr_r;
  logic [7:0]  n_r;
  logic [7:0]  idx_r;
  logic        rx;
  logic        run3;
  logic        ptr_bad;
  logic        op_valid_r;
  logic        bypass_r;
  logic        d2h_valid_r;
  logic [7:0]  d2h_data_r;
  logic        par_ok_r;
  logic        dbg_r;

  // ==========================================================
  // Link handshake
  assign data_ok = (addr_prev_r == flash_addr_r);
  assign rx      = LINK.h2d_valid && LINK.h2d_ready;

  // Accept only where a byte is consumed; lock swallows all
  always_comb begin
    unique case (state_r)
      ST_CMD, ST_PTR, ST_HUNT, ST_LOCK: LINK.h2d_ready = 1'b1; // R22
      ST_PW:                            LINK.h2d_ready = data_ok;
      default:                          LINK.h2d_ready = 1'b0;
    endcase
  end

  assign LINK.d2h_valid = d2h_valid_r;
  assign LINK.d2h_data  = d2h_data_r;
  assign FLASH_ADDR     = flash_addr_r;
  assign OP_VALID       = op_valid_r;
  assign OP_CMD         = cmd_r;
  assign OP_BYPASS      = bypass_r;
  assign LOCKED         = (state_r == ST_LOCK);
  assign BLANK          = blank_r;
  assign PROTECTED      = prot_r;
  assign PAR_ACCESS_OK  = par_ok_r;
  assign DEBUG_START    = dbg_r;

  // Pointer range checks once N is known
  always_comb begin
    ptr_bad = !in_win(len_ptr_r, WIN_HI); // R1 R2
    if (blank_r) begin
      ptr_bad = ptr_bad || !in_win(cmp_ptr_r, WIN_HI); // R8
    end else begin
      ptr_bad = ptr_bad || (FLASH_DATA < MIN_LEN) || // R2
                !in_win(cmp_ptr_r, CMP_LIMIT - {16'h0000, FLASH_DATA}); // R3
    end
  end

  // ==========================================================
  // Repeat detector on the password string
  run_check u_run (
    .clk   (CLK),
    .rst   (SYS_RST),
    .clear (state_r != ST_PW),
    .valid (rx && state_r == ST_PW),
    .data  (LINK.h2d_data),
    .run3  (run3)
  );

  // ==========================================================
  // Flash read address history
  always_ff @(posedge CLK) begin
    if (SYS_RST) addr_prev_r <= 16'h0000;
    else         addr_prev_r <= flash_addr_r;
  end

  // ==========================================================
  // Main sequencer
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state_r      <= ST_SCAN;
      flash_addr_r <= BLANK_LO;
      scan_r       <= 6'h00;
      blank_acc_r  <= 1'b1;
      blank_r      <= 1'b0;
      opt_free_r   <= 1'b0;
      cmd_r        <= 8'h00;
      ptr_cnt_r    <= 3'h0;
      len_ptr_r    <= 24'h000000;
      cmp_ptr_r    <= 24'h000000;
      n_r          <= 8'h00;
      idx_r        <= 8'h00;
      op_valid_r   <= 1'b0;
      bypass_r     <= 1'b0;
    end else begin
      op_valid_r <= 1'b0;
      unique case (state_r)
        // Blank check then option byte
        ST_SCAN: if (data_ok) begin
          if (scan_r == BLANK_CNT) begin
            opt_free_r <= (FLASH_DATA == ERASED); // R21
            blank_r    <= blank_acc_r; // R7
            state_r    <= ST_CMD;
          end else begin
            blank_acc_r  <= blank_acc_r && (FLASH_DATA == ERASED); // R7
            scan_r       <= scan_r + 6'h01;
            flash_addr_r <= (scan_r == BLANK_CNT - 6'h01) ? OPT_ADDR
                            : BLANK_LO + {10'h000, scan_r + 6'h01};
          end
        end
        ST_CMD: if (rx) begin
          cmd_r     <= LINK.h2d_data;
          ptr_cnt_r <= 3'h0;
          bypass_r  <= 1'b0;
          if (LINK.h2d_data == CMD_STATUS) begin
            state_r <= ST_CMD; // R20
          end else if (!gated_cmd(LINK.h2d_data)) begin
            state_r <= ST_LOCK;
          end else if (prot_r && LINK.h2d_data != CMD_ERASE) begin
            state_r <= ST_LOCK; // R18
          end else begin
            state_r <= ST_PTR; // R9
          end
        end
        // Length pointer then compare pointer, MSB first
        ST_PTR: if (rx) begin
          if (ptr_cnt_r < 3'h3) len_ptr_r <= {len_ptr_r[15:0], LINK.h2d_data};
          else                  cmp_ptr_r <= {cmp_ptr_r[15:0], LINK.h2d_data};
          ptr_cnt_r <= ptr_cnt_r + 3'h1;
          if (ptr_cnt_r == PTR_BYTES - 3'h1) begin
            state_r <= ST_LEN;
          end
        end
        ST_LEN: if (flash_addr_r != len_ptr_r[15:0]) begin
          flash_addr_r <= len_ptr_r[15:0];
        end else if (data_ok) begin
          n_r   <= FLASH_DATA;
          idx_r <= 8'h00;
          if (ptr_bad) begin
            state_r <= ST_LOCK; // R11
          end else if (blank_r) begin
            if (cmd_r == CMD_WRITE || cmd_r == CMD_LOADER) begin
              state_r <= ST_HUNT; // R12
            end else begin
              state_r    <= ST_BUSY; // R8
              op_valid_r <= 1'b1;
            end
          end else if (cmd_r == CMD_ERASE && opt_free_r) begin
            state_r    <= ST_BUSY; // R21
            op_valid_r <= 1'b1;
            bypass_r   <= 1'b1;
          end else begin
            state_r      <= ST_PW;
            flash_addr_r <= cmp_ptr_r[15:0];
          end
        end
        // Byte-by-byte compare against flash
        ST_PW: if (rx) begin
          if (LINK.h2d_data != FLASH_DATA || run3) begin
            state_r <= ST_LOCK; // R5 R10
          end else if (idx_r == n_r - 8'h01) begin
            state_r    <= ST_BUSY; // R4 R10
            op_valid_r <= 1'b1;
          end else begin
            idx_r        <= idx_r + 8'h01; // R4
            flash_addr_r <= flash_addr_r + 16'h0001;
          end
        end
        ST_HUNT: if (rx && LINK.h2d_data == REC_START) begin
          state_r    <= ST_BUSY; // R12
          op_valid_r <= 1'b1;
        end
        ST_BUSY: if (OP_ABORT) begin
          state_r <= ST_LOCK;
        end else if (CHIP_ERASE_DONE) begin
          state_r      <= ST_SCAN; // R15
          scan_r       <= 6'h00;
          blank_acc_r  <= 1'b1;
          flash_addr_r <= BLANK_LO;
        end else if (OP_DONE) begin
          state_r <= ST_CMD;
        end
        ST_LOCK: state_r <= ST_LOCK; // R6
      endcase
    end
  end

  // ==========================================================
  // Protection flag and authentication record
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      prot_r <= 1'b0;
      auth_r <= 1'b0;
    end else begin
      if (state_r == ST_BUSY && CHIP_ERASE_DONE && !OP_ABORT) begin
        prot_r <= 1'b0; // R19
        auth_r <= 1'b0;
      end else if (op_valid_r && cmd_r == CMD_SECURE) begin
        prot_r <= 1'b1; // R19
      end
      if (state_r == ST_PW && rx && LINK.h2d_data == FLASH_DATA && !run3 &&
          idx_r == n_r - 8'h01) begin
        auth_r <= 1'b1; // R17
      end
    end
  end

  // ==========================================================
  // Status response, parallel access and debug start
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      d2h_valid_r <= 1'b0;
      d2h_data_r  <= 8'h00;
      par_ok_r    <= 1'b0;
      dbg_r       <= 1'b0;
    end else begin
      d2h_valid_r <= rx && state_r == ST_CMD && LINK.h2d_data == CMD_STATUS; // R20
      if (rx && state_r == ST_CMD && LINK.h2d_data == CMD_STATUS) begin
        d2h_data_r             <= 8'h00;
        d2h_data_r[STAT_BLANK] <= blank_r; // R20
        d2h_data_r[STAT_PROT]  <= prot_r;
      end
      par_ok_r <= PAR_MODE && !prot_r; // R16 R18
      dbg_r    <= DEBUG_REQ && auth_r && state_r != ST_LOCK; // R17
    end
  end
endmodule : boot_gate

// ---- design/boot_ctl.sv ----
// Purpose: External controller end: sends command, pointers and password
// Assumes: PW_COUNT of zero means no password string
// Notes:   Remembers blank state from the last status answer
`timescale 1ns/100ps
module boot_ctl (
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  boot_link_if.ctl         LINK,
  input  wire logic        START,
  input  wire logic [7:0]  CMD,
  input  wire logic [23:0] LEN_PTR,
  input  wire logic [23:0] CMP_PTR,
  input  wire logic [7:0]  PW_COUNT,
  input  wire logic        PW_VALID,
  input  wire logic [7:0]  PW_DATA,
  output logic             PW_READY,
  output logic             BUSY,
  output logic             STAT_VALID,
  output logic [7:0]       STAT_DATA,
  output logic             SEEN_BLANK
);
  import boot_gate_pkg::*;

  typedef enum {H_IDLE, H_CMD, H_PTR, H_PW, H_WAIT} ctl_e;

  ctl_e        state_r;
  logic [7:0]  byte_r;
  logic        full_r;
  logic [47:0] ptrs_r;
  logic [2:0]  cnt_r;
  logic [7:0]  left_r;
  logic        blank_r;
  logic        stat_v_r;
  logic [7:0]  stat_d_r;
  logic        tx;

  assign tx             = LINK.h2d_valid && LINK.h2d_ready;
  assign LINK.h2d_valid = full_r;
  assign LINK.h2d_data  = byte_r;
  assign PW_READY       = (state_r == H_PW) && !full_r && (left_r != 8'h00);
  assign BUSY           = (state_r != H_IDLE);
  assign STAT_VALID     = stat_v_r;
  assign STAT_DATA      = stat_d_r;
  assign SEEN_BLANK     = blank_r;

  // ==========================================================
  // Transmit sequencer
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state_r <= H_IDLE;
      byte_r  <= 8'h00;
      full_r  <= 1'b0;
      ptrs_r  <= 48'h000000000000;
      cnt_r   <= 3'h0;
      left_r  <= 8'h00;
    end else begin
      if (tx) full_r <= 1'b0;
      unique case (state_r)
        H_IDLE: if (START) begin
          byte_r  <= CMD;
          full_r  <= 1'b1;
          ptrs_r  <= {LEN_PTR, CMP_PTR};
          cnt_r   <= 3'h0;
          // No string to a blank part for erase, write or loader
          left_r  <= (blank_r && (CMD == CMD_ERASE || CMD == CMD_WRITE ||
                      CMD == CMD_LOADER)) ? 8'h00 : PW_COUNT; // R13 R14
          state_r <= H_CMD;
        end
        H_CMD: if (tx) begin
          state_r <= (byte_r == CMD_STATUS) ? H_WAIT : H_PTR;
        end
        H_PTR: if (!full_r || tx) begin
          if (cnt_r == PTR_BYTES) begin
            state_r <= H_PW;
          end else begin
            byte_r <= ptrs_r[47:40]; // R8
            full_r <= 1'b1;
            ptrs_r <= {ptrs_r[39:0], 8'h00};
            cnt_r  <= cnt_r + 3'h1;
          end
        end
        H_PW: if (left_r == 8'h00) begin
          if (!full_r || tx) state_r <= H_IDLE;
        end else if (PW_VALID && PW_READY) begin
          byte_r <= PW_DATA; // R4
          full_r <= 1'b1;
          left_r <= left_r - 8'h01;
        end
        H_WAIT: if (LINK.d2h_valid) begin
          state_r <= H_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Status answer capture
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      stat_v_r <= 1'b0;
      stat_d_r <= 8'h00;
      blank_r  <= 1'b0;
    end else begin
      stat_v_r <= LINK.d2h_valid;
      if (LINK.d2h_valid) begin
        stat_d_r <= LINK.d2h_data;
        blank_r  <= LINK.d2h_data[STAT_BLANK];
      end
    end
  end
endmodule : boot_ctl

// ---- verification/boot_gate_sva.sv ----
// Purpose: Checks on the boot link and the gate outputs
// Assumes: One clock, synchronous active-high reset
// Notes:   Instantiated beside the link interface in the bench top
`timescale 1ns/100ps
module boot_gate_checker (
  input wire logic       CLK,
  input wire logic       SYS_RST,
  input wire logic       h2d_valid,
  input wire logic [7:0] h2d_data,
  input wire logic       h2d_ready,
  input wire logic       d2h_valid,
  input wire logic [7:0] d2h_data,
  input wire logic       LOCKED,
  input wire logic       OP_VALID,
  input wire logic [7:0] OP_CMD,
  input wire logic       BLANK,
  input wire logic       PROTECTED,
  input wire logic       PAR_MODE,
  input wire logic       PAR_ACCESS_OK,
  input wire logic       DEBUG_REQ,
  input wire logic       DEBUG_START,
  input wire logic       CHIP_ERASE_DONE
);
  import boot_gate_pkg::*;
  // ==========================================================
  // Assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  a_lock_sticky: assert property (LOCKED |=> LOCKED)
    else $error("lock left without reset");
  a_lock_silent: assert property (LOCKED && $past(LOCKED) |-> !d2h_valid)
    else $error("answer sent while locked");
  a_lock_drains: assert property (LOCKED |-> h2d_ready)
    else $error("locked gate stalls the link");
  a_lock_no_grant: assert property (LOCKED |-> !OP_VALID)
    else $error("grant while locked");
  a_status_bits: assert property (d2h_valid |-> d2h_data == {6'h00, PROTECTED, BLANK})
    else $error("status byte wrong");
  a_par_access: assert property (!$past(SYS_RST) |->
                                 PAR_ACCESS_OK == $past(PAR_MODE && !PROTECTED))
    else $error("parallel access flag wrong");
  a_debug_gate: assert property (DEBUG_START |-> $past(DEBUG_REQ) && !$past(LOCKED))
    else $error("debug start without request");
  a_prot_clear: assert property ($fell(PROTECTED) |->
                                 $past(CHIP_ERASE_DONE) || $past(SYS_RST))
    else $error("protection cleared without chip erase");
  a_prot_set: assert property ($rose(PROTECTED) |->
                               ($past(OP_VALID) || $past(OP_VALID, 2)) && OP_CMD == CMD_SECURE)
    else $error("protection set without command");

  // Main scenarios reached
  c_grant: cover property (OP_VALID);
  c_lock: cover property ($rose(LOCKED));
  c_status: cover property (h2d_valid && h2d_ready && h2d_data == CMD_STATUS);
  c_protect: cover property ($rose(PROTECTED));
endmodule : boot_gate_checker

// ---- verification/boot_password_gate_tb_top.sv ----
// Purpose: Both ends of the boot link driven from the controller user side
// Assumes: Flash model with one-cycle synchronous read
// Notes:   Every lock case is followed by a reset and a fresh flash image
`timescale 1ns/100ps
module boot_password_gate_tb_top;
  import boot_gate_pkg::*;
  logic        clk, rst, start, pw_valid, pw_ready, busy, stat_valid, seen_blank;
  logic        par_mode, debug_req, op_done, erase_done, op_valid, op_bypass, locked;
  logic        blank, prot, par_ok, debug_start, bypass_seen, op_abort, sector_erase;
  logic [7:0]  cmd, pw_count, pw_data, stat_data, stat_last, last_cmd, op_cmd, flash_data;
  logic [23:0] len_ptr, cmp_ptr;
  logic [15:0] flash_addr;
  logic [7:0]  mem [0:65535];
  logic [7:0]  pwbuf [0:23];
  int          grants, stat_count, fail_count, num_checks, g, i;
  // Lock cases: wrong string, triple run, short length, bad pointers, blank window
  logic [7:0]  lc_cmd [6] = '{CMD_WRITE, CMD_LOADER, CMD_READ, CMD_ERASE, CMD_SECURE, CMD_READ};
  logic [23:0] lc_lp [6] = '{24'h008100, 24'h008101, 24'h008102, 24'h007fff, 24'h008100,
                             24'h008000};
  logic [23:0] lc_cp [6] = '{24'h009000, 24'h009100, 24'h009000, 24'h009000, 24'h00fef9,
                             24'h00ff00};
  int          lc_sel [6] = '{8, 16, 0, 0, 0, 0};

  boot_link_if link ();
  boot_gate i_boot_gate (.CLK(clk), .SYS_RST(rst), .LINK(link), .FLASH_ADDR(flash_addr),
    .FLASH_DATA(flash_data), .PAR_MODE(par_mode), .DEBUG_REQ(debug_req), .OP_DONE(op_done),
    .OP_ABORT(op_abort), .CHIP_ERASE_DONE(erase_done), .OP_VALID(op_valid), .OP_CMD(op_cmd),
    .OP_BYPASS(op_bypass), .LOCKED(locked), .BLANK(blank), .PROTECTED(prot),
    .PAR_ACCESS_OK(par_ok), .DEBUG_START(debug_start));
  boot_ctl i_boot_ctl (.CLK(clk), .SYS_RST(rst), .LINK(link), .START(start), .CMD(cmd),
    .LEN_PTR(len_ptr), .CMP_PTR(cmp_ptr), .PW_COUNT(pw_count), .PW_VALID(pw_valid),
    .PW_DATA(pw_data), .PW_READY(pw_ready), .BUSY(busy), .STAT_VALID(stat_valid),
    .STAT_DATA(stat_data), .SEEN_BLANK(seen_blank));
  boot_gate_checker i_boot_gate_checker (.CLK(clk), .SYS_RST(rst),
    .h2d_valid(link.h2d_valid), .h2d_data(link.h2d_data), .h2d_ready(link.h2d_ready),
    .d2h_valid(link.d2h_valid), .d2h_data(link.d2h_data), .LOCKED(locked),
    .OP_VALID(op_valid), .OP_CMD(op_cmd), .BLANK(blank), .PROTECTED(prot),
    .PAR_MODE(par_mode), .PAR_ACCESS_OK(par_ok), .DEBUG_REQ(debug_req),
    .DEBUG_START(debug_start), .CHIP_ERASE_DONE(erase_done));

  // ==========================================================
  // Clock, flash read, operation side and status capture
  always #5 clk = ~clk;

  always @(posedge clk) begin
    flash_data <= mem[flash_addr];
    op_done    <= 1'b0;
    erase_done <= 1'b0;
    op_abort   <= 1'b0;
    if (stat_valid === 1'b1) begin
      stat_count <= stat_count + 1;
      stat_last  <= stat_data;
    end
    if (op_valid === 1'b1) begin
      grants      <= grants + 1;
      last_cmd    <= op_cmd;
      bypass_seen <= op_bypass;
      if (op_cmd == CMD_ERASE && op_bypass && sector_erase) begin
        op_abort <= 1'b1;
      end else if (op_cmd == CMD_ERASE) begin
        erase_done <= 1'b1;
        for (int a = 0; a < 65536; a++) mem[a] = ERASED;
      end else begin
        op_done <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Tasks
  task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic load(input logic blank_part, input logic [7:0] opt);
    for (int a = 0; a < 65536; a++) mem[a] = ERASED;
    if (!blank_part) begin
      mem[16'hffe0] = 8'h00;
      mem[OPT_ADDR] = opt;
      mem[16'h8100] = 8'h08;
      mem[16'h8101] = 8'h08;
      mem[16'h8102] = 8'h06;
      for (int k = 0; k < 8; k++) begin
        mem[16'h9000 + k] = pwbuf[k];
        mem[16'hfef8 + k] = pwbuf[k];
        mem[16'h9100 + k] = pwbuf[16 + k];
      end
    end
  endtask : load

  task automatic reset_dut();
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
  endtask : reset_dut

  task automatic run(input logic [7:0] c, input logic [23:0] lp, input logic [23:0] cp,
                     input logic [7:0] n, input int sel);
    int k;
    k = 0;
    start    <= 1'b1;
    cmd      <= c;
    len_ptr  <= lp;
    cmp_ptr  <= cp;
    pw_count <= n;
    pw_valid <= (n != 8'h00);
    pw_data  <= pwbuf[sel];
    @(posedge clk);
    start <= 1'b0;
    for (int t = 0; t < 600; t++) begin
      @(posedge clk);
      if (pw_valid && pw_ready === 1'b1) begin
        k++;
        pw_valid <= (k < n);
        pw_data  <= pwbuf[sel + k];
      end
      if (k >= n && busy === 1'b0 && t > 2) break;
    end
    repeat (8) @(posedge clk);
  endtask : run

  task automatic status(input logic [7:0] exp, input logic fresh);
    int s;
    s = stat_count;
    run(CMD_STATUS, 24'h000000, 24'h000000, 8'h00, 0);
    check("status count", 8'(stat_count - s), {7'h00, fresh});
    if (fresh) check("status byte", stat_last, exp);
  endtask : status

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test

  // ==========================================================
  // Tests
  initial begin
    clk = 0; rst = 1; start = 0; pw_valid = 0; par_mode = 0; debug_req = 0;
    op_abort = 0;
    sector_erase = 0;
    cmd = 0; pw_count = 0; pw_data = 0; len_ptr = 0; cmp_ptr = 0; flash_data = 0;
    op_done = 0; erase_done = 0; grants = 0; stat_count = 0; fail_count = 0; num_checks = 0;
    for (i = 0; i < 8; i++) begin
      pwbuf[i]      = 8'(8'h11 * (i + 1));
      pwbuf[8 + i]  = (i == 7) ? 8'h99 : 8'(8'h11 * (i + 1));
      pwbuf[16 + i] = (i < 3) ? 8'h5a : 8'(i - 2);
    end
    load(1'b0, 8'h00);
    reset_dut();
    status(8'h00, 1'b1);
    run(CMD_READ, 24'h008100, 24'h009000, 8'h08, 0);
    check("grants", 8'(grants), 8'h01);
    check("granted cmd", last_cmd, CMD_READ);
    debug_req <= 1'b1;
    par_mode  <= 1'b1;
    repeat (3) @(posedge clk);
    check("debug start", debug_start, 8'h01);
    check("parallel access", par_ok, 8'h01);
    $display("test auth_read done");
    run(CMD_SECURE, 24'h008100, 24'h00fef8, 8'h08, 0);
    check("protected", prot, 8'h01);
    check("parallel access", par_ok, 8'h00);
    status(8'h02, 1'b1);
    run(CMD_ERASE, 24'h008100, 24'h009000, 8'h08, 0);
    repeat (120) @(posedge clk);
    check("protected", prot, 8'h00);
    check("blank", blank, 8'h01);
    status(8'h01, 1'b1);
    check("seen blank", seen_blank, 8'h01);
    run(CMD_READ, 24'h008000, 24'h00feff, 8'h00, 0);
    check("grants", 8'(grants), 8'h04);
    $display("test protect_erase done");
    for (i = 0; i < 6; i++) begin
      load(i == 5, 8'h00);
      reset_dut();
      g = grants;
      run(lc_cmd[i], lc_lp[i], lc_cp[i], (i == 5) ? 8'h00 : 8'h08, lc_sel[i]);
      check("locked", locked, 8'h01);
      check("no grant", 8'(grants - g), 8'h00);
      check("debug start", debug_start, 8'h00);
      status(8'h00, 1'b0);
    end
    $display("test lock_cases done");
    load(1'b0, 8'hff);
    reset_dut();
    g = grants;
    run(CMD_ERASE, 24'h008100, 24'h009000, 8'h00, 0);
    check("locked", locked, 8'h00);
    check("grants", 8'(grants - g), 8'h01);
    check("bypass", bypass_seen, 8'h01);
    $display("test erase_bypass done");
    // Sector erase under bypass must be refused
    load(1'b0, 8'hff);
    reset_dut();
    sector_erase <= 1'b1;
    run(CMD_ERASE, 24'h008100, 24'h009000, 8'h00, 0);
    check("locked", locked, 8'h01);
    sector_erase <= 1'b0;
    $display("test sector_abort done");
    // Blank write: junk dropped until record start mark
    load(1'b1, 8'h00);
    reset_dut();
    g = grants;
    pwbuf[19] = REC_START;
    run(CMD_WRITE, 24'h008000, 24'h008000, 8'h04, 16);
    check("grants", 8'(grants - g), 8'h01);
    check("granted cmd", last_cmd, CMD_WRITE);
    check("locked", locked, 8'h00);
    $display("test record_hunt done");
    stop_test();
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    $display("ERROR watchdog expected end seen timeout");
    stop_test();
  end
endmodule : boot_password_gate_tb_top
